// >>> pulse_out_pkg.sv
package pulse_out_pkg;

  // system clock rate and time figures
  localparam int CLK_HZ_DEF = 20_000_000;
  localparam longint NS_PER_S = 1_000_000_000;
  localparam longint WIDTH_20US_NS = 20_000;
  localparam longint WIDTH_1MS_NS = 1_000_000;
  localparam longint WIDTH_100MS_NS = 100_000_000;
  localparam longint WIDTH_500MS_NS = 500_000_000;
  localparam longint HALF_SEC_NS = 500_000_000;

  // register byte offsets
  localparam logic [7:0] REG_PPS_WIDTH = 8'h00;
  localparam logic [7:0] REG_PPO_MODE = 8'h04;
  localparam logic [7:0] REG_DDS_RATE = 8'h08;
  localparam logic [7:0] REG_TCODE_FMT = 8'h0c;
  localparam logic [7:0] REG_TRIG_ADD = 8'h10;
  localparam logic [7:0] REG_TRIG_STAT = 8'h14;

  // field positions
  localparam int TRIG_SEC_LSB = 0;
  localparam int TRIG_MIN_LSB = 8;
  localparam int TRIG_HOUR_LSB = 16;
  localparam int STAT_ARMED_BIT = 8;
  localparam int STAT_OVF_BIT = 9;

  localparam logic [5:0] LAST_SEC = 6'h3b;
  localparam logic [5:0] LAST_MIN = 6'h3b;
  localparam logic [4:0] LAST_HOUR = 5'h17;
  localparam logic [23:0] DDS_RATE_MAX = 24'h989680;

  typedef enum logic [1:0] {
    W_20US = 2'b00,
    W_1MS = 2'b01,
    W_100MS = 2'b10,
    W_500MS = 2'b11
  } width_sel_t;

  typedef enum logic [3:0] {
    PPO_OFF = 4'h0,
    PPO_RATE_1 = 4'h1,
    PPO_RATE_10 = 4'h2,
    PPO_RATE_100 = 4'h3,
    PPO_RATE_1K = 4'h4,
    PPO_RATE_10K = 4'h5,
    PPO_RATE_100K = 4'h6,
    PPO_RATE_1M = 4'h7,
    PPO_RATE_10M = 4'h8,
    PPO_PULSE_PER_MINUTE = 4'h9,
    PPO_PULSE_EVERY_TWO_SECONDS = 4'ha,
    PPO_INVERTED = 4'hb
  } ppo_mode_t;

  typedef enum logic {
    TRIG_IDLE = 1'b0,
    TRIG_ARMED = 1'b1
  } trig_state_t;

  // reset values; format 0 means B122 on the AM output and B002 on the level output
  localparam width_sel_t PPS_WIDTH_RST = W_1MS;
  localparam ppo_mode_t PPO_MODE_RST = PPO_OFF;
  localparam logic [23:0] DDS_RATE_RST = 24'h000000;
  localparam logic [1:0] TCODE_FMT_RST = 2'h0;

  function automatic int nsToCycles(input int clkHz, input longint ns);
    longint c;
    c = (longint'(clkHz) * ns + NS_PER_S - 1) / NS_PER_S;
    if (c < 1) c = 1;
    return int'(c);
  endfunction

  function automatic int widthCycles(input int clkHz, input width_sel_t sel);
    case (sel)
      W_20US: return nsToCycles(clkHz, WIDTH_20US_NS);
      W_1MS: return nsToCycles(clkHz, WIDTH_1MS_NS);
      W_100MS: return nsToCycles(clkHz, WIDTH_100MS_NS);
      default: return nsToCycles(clkHz, WIDTH_500MS_NS);
    endcase
  endfunction

endpackage

// >>> pulse_stretch.sv
`timescale 1ns/1ps
module pulse_stretch
  import pulse_out_pkg::*;
#(
  parameter int CLK_HZ = CLK_HZ_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire width_sel_t widthSel,
  output logic level
);

  logic [31:0] cnt_reg;
  logic level_reg;
  logic [31:0] target;

  assign target = 32'(widthCycles(CLK_HZ, widthSel));
  assign level = level_reg;

  // a new start always restarts the count, even inside a running pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      level_reg <= 1'b0;
      cnt_reg <= 32'h0;
    end else if (start) begin
      level_reg <= 1'b1;
      cnt_reg <= 32'h0;
    end else if (level_reg) begin
      if (cnt_reg >= target - 32'h1) begin
        level_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg + 32'h1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  widthEnd_a: assert property (level_reg && !start && cnt_reg == target - 32'h1 |=> !level_reg)
    else $error("pulse did not end at its width");
  widthStart_a: assert property (start |=> level_reg && cnt_reg == 32'h0)
    else $error("pulse did not start on request");

endmodule

// >>> dds_synth.sv
`timescale 1ns/1ps
module dds_synth
  import pulse_out_pkg::*;
#(
  parameter int CLK_HZ = CLK_HZ_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [23:0] rate,
  output logic synthOut
);

  localparam logic [31:0] MODULUS = 32'(CLK_HZ);
  localparam logic [31:0] HALF = 32'(CLK_HZ / 2);

  logic [31:0] acc_reg;
  logic [31:0] acc_next;
  logic out_reg;

  // exact 1 Hz steps: the phase wraps at the clock rate, not at a power of two
  // modulo rather than one subtraction: a rate above the clock aliases but stays in range
  always_comb begin
    acc_next = (acc_reg + {8'h00, rate}) % MODULUS;
  end

  // free running on the oscillator; second marks never touch the phase
  always_ff @(posedge clk) begin
    if (rst || rate == 24'h0) begin
      acc_reg <= 32'h0;
      out_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      out_reg <= acc_reg < HALF;
    end
  end

  assign synthOut = out_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ddsIdle_a: assert property (rate == 24'h0 |=> !out_reg && acc_reg == 32'h0)
    else $error("synthesized output not idle at zero rate");
  ddsPhase_a: assert property (rate != 24'h0 && $stable(rate) |=> acc_reg < MODULUS)
    else $error("phase accumulator left its range");

endmodule

// >>> on_time_pulse_outputs.sv
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module on_time_pulse_outputs
  import pulse_out_pkg::*;
#(
  parameter int CLK_HZ = CLK_HZ_DEF,
  parameter int NUM_TRIG = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic secondMark,
  input wire logic [4:0] timeHour,
  input wire logic [5:0] timeMinute,
  input wire logic [5:0] timeSecond,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  output logic ppsOut,
  output logic programmablePulseOutput,
  output logic ddsOut,
  output logic [1:0] timeCodeFormat
);

  localparam int IDXW = (NUM_TRIG > 1) ? $clog2(NUM_TRIG) : 1;
  localparam logic [31:0] HALF_CYC = 32'(nsToCycles(CLK_HZ, HALF_SEC_NS));

  width_sel_t ppsWidth_reg;
  ppo_mode_t ppoMode_reg;
  logic [23:0] ddsRate_reg;
  logic [1:0] tcodeFmt_reg;
  logic [NUM_TRIG-1:0] slotValid_reg;
  logic [16:0] slotTime_reg [NUM_TRIG];
  trig_state_t trigState_reg;
  trig_state_t trigState_next;
  logic trigFired_reg;
  logic overflow_reg;
  logic [31:0] secCnt_reg;
  logic [31:0] rateCnt_reg;
  logic ppsOut_reg;
  logic ppoOut_reg;
  logic [31:0] regRdData_reg;

  logic halfPoint;
  logic [16:0] upcoming;
  logic [NUM_TRIG-1:0] slotHit;
  logic [IDXW-1:0] freeIdx;
  logic haveFree;
  logic trigWrite;
  logic trigFire;
  logic ppoEvent;
  logic ppsLevel;
  logic evLevel;
  logic rateLevel;
  logic [31:0] period;
  logic ppoNext;

  function automatic logic [16:0] nextTime(input logic [16:0] t);
    logic [4:0] h;
    logic [5:0] m;
    logic [5:0] s;
    h = t[16:12];
    m = t[11:6];
    s = t[5:0];
    if (s == LAST_SEC) begin
      s = 6'h00;
      if (m == LAST_MIN) begin
        m = 6'h00;
        h = (h == LAST_HOUR) ? 5'h00 : h + 5'h01;
      end else begin
        m = m + 6'h01;
      end
    end else begin
      s = s + 6'h01;
    end
    return {h, m, s};
  endfunction

  function automatic logic [31:0] ratePeriod(input ppo_mode_t m);
    int p;
    p = CLK_HZ;
    // fixed bound keeps the loop static; codes past the top rate clamp below anyway
    for (int k = 1; k <= 8; k++) begin
      if (k < int'(m)) p = p / 10;
    end
    if (p < 2) p = 2;
    return 32'(p);
  endfunction

  // ---------------- register port ----------------
  assign trigWrite = regWr && regAddr == REG_TRIG_ADD;

  always_ff @(posedge clk) begin
    if (rst) begin
      ppsWidth_reg <= PPS_WIDTH_RST;
    end else if (regWr && regAddr == REG_PPS_WIDTH) begin
      ppsWidth_reg <= width_sel_t'(regWrData[1:0]);
    end
  end

  // undefined mode codes are ignored so the output never enters a dead state
  always_ff @(posedge clk) begin
    if (rst) begin
      ppoMode_reg <= PPO_MODE_RST;
    end else if (regWr && regAddr == REG_PPO_MODE && regWrData[3:0] <= PPO_INVERTED) begin
      ppoMode_reg <= ppo_mode_t'(regWrData[3:0]);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ddsRate_reg <= DDS_RATE_RST;
    end else if (regWr && regAddr == REG_DDS_RATE) begin
      if (regWrData[31:24] != 8'h00 || regWrData[23:0] > DDS_RATE_MAX) begin
        ddsRate_reg <= DDS_RATE_MAX;
      end else begin
        ddsRate_reg <= regWrData[23:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tcodeFmt_reg <= TCODE_FMT_RST;
    end else if (regWr && regAddr == REG_TCODE_FMT) begin
      tcodeFmt_reg <= regWrData[1:0];
    end
  end

  // read data stand for exactly one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst || !regRd) begin
      regRdData_reg <= 32'h0;
    end else begin
      case (regAddr)
        REG_PPS_WIDTH: regRdData_reg <= {30'h0, ppsWidth_reg};
        REG_PPO_MODE: regRdData_reg <= {28'h0, ppoMode_reg};
        REG_DDS_RATE: regRdData_reg <= {8'h00, ddsRate_reg};
        REG_TCODE_FMT: regRdData_reg <= {30'h0, tcodeFmt_reg};
        REG_TRIG_STAT: begin
          regRdData_reg <= 32'h0;
          regRdData_reg[NUM_TRIG-1:0] <= slotValid_reg;
          regRdData_reg[STAT_ARMED_BIT] <= trigState_reg == TRIG_ARMED;
          regRdData_reg[STAT_OVF_BIT] <= overflow_reg;
        end
        default: regRdData_reg <= 32'h0;
      endcase
    end
  end

  // ---------------- second phase ----------------
  always_ff @(posedge clk) begin
    if (rst || secondMark) begin
      secCnt_reg <= 32'h0;
    end else if (secCnt_reg < HALF_CYC) begin
      secCnt_reg <= secCnt_reg + 32'h1;
    end
  end

  // a missing mark leaves halfPoint silent, so nothing arms off a stale time
  assign halfPoint = !secondMark && secCnt_reg == HALF_CYC - 32'h1;
  assign upcoming = nextTime({timeHour, timeMinute, timeSecond});

  // ---------------- trigger slots ----------------
  for (genvar i = 0; i < NUM_TRIG; i++) begin : g_hit
    assign slotHit[i] = slotValid_reg[i] && slotTime_reg[i] == upcoming;
  end

  always_comb begin
    freeIdx = '0;
    haveFree = 1'b0;
    for (int i = NUM_TRIG - 1; i >= 0; i--) begin
      if (!slotValid_reg[i]) begin
        freeIdx = IDXW'(i);
        haveFree = 1'b1;
      end
    end
  end

  // a slot is consumed when it arms; freeIdx only names empty slots
  always_ff @(posedge clk) begin
    if (rst) begin
      slotValid_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_TRIG; i++) begin
        if (trigWrite && haveFree && freeIdx == IDXW'(i)) begin
          slotValid_reg[i] <= 1'b1;
          slotTime_reg[i] <= {regWrData[TRIG_HOUR_LSB +: 5], regWrData[TRIG_MIN_LSB +: 6],
                              regWrData[TRIG_SEC_LSB +: 6]};
        end else if (halfPoint && trigState_reg == TRIG_IDLE && slotHit[i]) begin
          slotValid_reg[i] <= 1'b0;
        end
      end
    end
  end

  // set wins over the clear written in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      overflow_reg <= 1'b0;
    end else if (trigWrite && !haveFree) begin
      overflow_reg <= 1'b1;
    end else if (regWr && regAddr == REG_TRIG_STAT && regWrData[STAT_OVF_BIT]) begin
      overflow_reg <= 1'b0;
    end
  end

  always_comb begin
    trigState_next = trigState_reg;
    case (trigState_reg)
      TRIG_IDLE: if (halfPoint && |slotHit) trigState_next = TRIG_ARMED;
      TRIG_ARMED: if (halfPoint) trigState_next = TRIG_IDLE;
      default: trigState_next = TRIG_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trigState_reg <= TRIG_IDLE;
    end else begin
      trigState_reg <= trigState_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || trigState_reg == TRIG_IDLE) begin
      trigFired_reg <= 1'b0;
    end else if (secondMark) begin
      trigFired_reg <= 1'b1;
    end
  end

  assign trigFire = trigState_reg == TRIG_ARMED && secondMark && !trigFired_reg;

  // ---------------- pulse generation ----------------
  assign ppoEvent = trigFire ||
    (ppoMode_reg == PPO_PULSE_PER_MINUTE && secondMark && timeSecond == 6'h00) ||
    (ppoMode_reg == PPO_PULSE_EVERY_TWO_SECONDS && secondMark && !timeSecond[0]);

  pulse_stretch #(.CLK_HZ(CLK_HZ)) u_pps (
    .clk(clk),
    .rst(rst),
    .start(secondMark),
    .widthSel(ppsWidth_reg),
    .level(ppsLevel)
  );

  pulse_stretch #(.CLK_HZ(CLK_HZ)) u_event (
    .clk(clk),
    .rst(rst),
    .start(ppoEvent),
    .widthSel(ppsWidth_reg),
    .level(evLevel)
  );

  assign period = ratePeriod(ppoMode_reg);

  // the rate divider restarts on every mark so each second begins with the output high
  always_ff @(posedge clk) begin
    if (rst || secondMark || rateCnt_reg >= period - 32'h1) begin
      rateCnt_reg <= 32'h0;
    end else begin
      rateCnt_reg <= rateCnt_reg + 32'h1;
    end
  end

  assign rateLevel = rateCnt_reg < (period >> 1);

  always_comb begin
    case (ppoMode_reg)
      PPO_OFF: ppoNext = evLevel;
      PPO_RATE_1: ppoNext = ppsLevel || evLevel;
      PPO_PULSE_PER_MINUTE, PPO_PULSE_EVERY_TWO_SECONDS: ppoNext = evLevel;
      PPO_INVERTED: ppoNext = !ppsLevel || evLevel;
      default: ppoNext = rateLevel || evLevel;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ppsOut_reg <= 1'b0;
      ppoOut_reg <= 1'b0;
    end else begin
      ppsOut_reg <= ppsLevel;
      ppoOut_reg <= ppoNext;
    end
  end

  dds_synth #(.CLK_HZ(CLK_HZ)) u_dds (
    .clk(clk),
    .rst(rst),
    .rate(ddsRate_reg),
    .synthOut(ddsOut)
  );

  assign ppsOut = ppsOut_reg;
  assign programmablePulseOutput = ppoOut_reg;
  assign timeCodeFormat = tcodeFmt_reg;
  assign regRdData = regRdData_reg;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence armAtHalf;
    trigState_reg == TRIG_IDLE && halfPoint && |slotHit;
  endsequence

  sequence fireAtMark;
    trigState_reg == TRIG_ARMED && secondMark && !trigFired_reg;
  endsequence

  ppsRise_a: assert property (secondMark |=> ##1 ppsOut)
    else $error("pps did not rise two cycles after the mark");
  widthDefault_a: assert property ($fell(rst) |-> ppsWidth_reg == W_1MS)
    else $error("pps width not at its reset value");
  minuteOnly_a: assert property (ppoMode_reg == PPO_PULSE_PER_MINUTE && secondMark &&
                                 timeSecond != 6'h00 && trigState_reg == TRIG_IDLE |-> !ppoEvent)
    else $error("per-minute pulse off the minute");
  evenOnly_a: assert property (ppoMode_reg == PPO_PULSE_EVERY_TWO_SECONDS && secondMark &&
                               timeSecond[0] && trigState_reg == TRIG_IDLE |-> !ppoEvent)
    else $error("two-second pulse on an odd second");
  invertOut_a: assert property (ppoMode_reg == PPO_INVERTED && !evLevel &&
                                $stable(ppoMode_reg) |=> ppoOut_reg == !$past(ppsLevel))
    else $error("inverted output not the complement");
  rateAlign_a: assert property (secondMark && ppoMode_reg >= PPO_RATE_10 &&
                                ppoMode_reg <= PPO_RATE_10M && $stable(ppoMode_reg) |=> ##1 ppoOut_reg)
    else $error("rate output not aligned to the mark");
  armTrig_a: assert property (armAtHalf |=> trigState_reg == TRIG_ARMED)
    else $error("trigger not armed half a second ahead");
  fireTrig_a: assert property (fireAtMark |=> evLevel ##1 ppoOut_reg)
    else $error("armed trigger gave no pulse at the mark");
  disarmTrig_a: assert property (trigState_reg == TRIG_ARMED && halfPoint
                                 |=> trigState_reg == TRIG_IDLE)
    else $error("trigger not disarmed after the mark");
  oneShot_a: assert property (trigState_reg == TRIG_ARMED && (trigFired_reg || secondMark)
                              |=> trigFired_reg || trigState_reg == TRIG_IDLE)
    else $error("armed trigger could fire twice");

endmodule

// >>> pulse_receiver.sv
`timescale 1ns/1ps
// stands in for timing gear on one output: edge count, edge time, high width
module pulse_receiver (
  input wire logic clk,
  input wire logic rst,
  input wire logic sig,
  output logic [31:0] now,
  output logic [31:0] rises,
  output logic [31:0] riseAt,
  output logic [31:0] width
);
  logic prevLvl;
  logic [31:0] hiCnt;

  // width is counted in sampled-high cycles, so it compares directly with clock counts
  always_ff @(posedge clk) begin
    if (rst) begin
      now <= '0;
      rises <= '0;
      riseAt <= '0;
      width <= '0;
      hiCnt <= '0;
      prevLvl <= 1'b0;
    end else begin
      now <= now + 1;
      prevLvl <= sig;
      if (sig && !prevLvl) begin
        rises <= rises + 1;
        riseAt <= now;
        hiCnt <= 32'h1;
      end else if (sig) begin
        hiCnt <= hiCnt + 1;
      end
      if (!sig && prevLvl) begin
        width <= hiCnt;
      end
    end
  end
endmodule

// >>> tb.sv
`timescale 1ns/1ps
module tb;
  import pulse_out_pkg::*;
  localparam int HZ = 2000;
  localparam int SEC = HZ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic secondMark = 1'b0;
  logic [4:0] timeHour = 5'h0;
  logic [5:0] timeMinute = 6'h0;
  logic [5:0] timeSecond = 6'h0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData;
  logic ppsOut;
  logic programmablePulseOutput;
  logic ddsOut;
  logic [1:0] timeCodeFormat;
  logic [31:0] ppsNow, ppsRises, ppsRise, ppsWidth;
  logic [31:0] ppoRises, ppoRise, ppoWidth, ddsRises;
  logic [31:0] markAt = 32'h0;
  logic [31:0] r0;
  int failures = 0;
  int num_checks = 0;
  int sod = 13 * 3600 + 49 * 60 + 50;
  int markCnt = 0;
  int wTab [4] = '{1, 2, 200, 1000};

  always #25 clk = ~clk;

  on_time_pulse_outputs #(.CLK_HZ(HZ), .NUM_TRIG(4)) on_time_pulse_outputs_inst (
    .clk(clk), .rst(rst), .secondMark(secondMark), .timeHour(timeHour),
    .timeMinute(timeMinute), .timeSecond(timeSecond), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .ppsOut(ppsOut), .programmablePulseOutput(programmablePulseOutput),
    .ddsOut(ddsOut), .timeCodeFormat(timeCodeFormat));
  pulse_receiver ppsRx (.clk(clk), .rst(rst), .sig(ppsOut), .now(ppsNow),
    .rises(ppsRises), .riseAt(ppsRise), .width(ppsWidth));
  pulse_receiver ppoRx (.clk(clk), .rst(rst), .sig(programmablePulseOutput), .now(),
    .rises(ppoRises), .riseAt(ppoRise), .width(ppoWidth));
  pulse_receiver ddsRx (.clk(clk), .rst(rst), .sig(ddsOut), .now(),
    .rises(ddsRises), .riseAt(), .width());

  // time base: one mark per second, time of the second that begins at it
  always @(posedge clk) begin
    if (rst) begin
      markCnt <= 0;
      secondMark <= 1'b0;
    end else if (markCnt == SEC - 1) begin
      markCnt <= 0;
      secondMark <= 1'b1;
      timeHour <= 5'(sod / 3600);
      timeMinute <= 6'((sod / 60) % 60);
      timeSecond <= 6'(sod % 60);
      sod = sod + 1;
    end else begin
      markCnt <= markCnt + 1;
      secondMark <= 1'b0;
    end
  end

  always @(posedge clk) if (secondMark === 1'b1) markAt <= ppsNow;

  task automatic final_report;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", n, e, g);
    end
  endtask

  // phase of the accumulator makes the count one off either way
  task automatic chkNear(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if ($isunknown(g) || g + 1 < e || g > e + 1) begin
      failures++;
      $display("[ERR] %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(n, e, regRdData);
  endtask

  task automatic marks(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (secondMark !== 1'b1 && k < 2 * SEC + 10);
      if (k >= 2 * SEC + 10) begin
        failures++;
        $display("[ERR] secondMark expected 1 seen timeout");
        final_report();
      end
    end
    #1;
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  function automatic logic [31:0] trigWord(input int h, input int m, input int s);
    return (32'(h) << TRIG_HOUR_LSB) | (32'(m) << TRIG_MIN_LSB) | (32'(s) << TRIG_SEC_LSB);
  endfunction

  function automatic int nPer(input int m);
    int p;
    p = HZ;
    for (int j = 1; j < m; j++) p = p / 10;
    if (p < 2) p = 2;
    return (SEC - 10) / p + 1;
  endfunction

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdChk(REG_PPS_WIDTH, 32'h1, "width");
    chk("rdHold", 32'h1, regRdData);
    waitCyc(1);
    chk("rdAfter", 32'h0, regRdData);
    rdChk(REG_PPO_MODE, 32'h0, "mode");
    rdChk(REG_DDS_RATE, 32'h0, "rate");
    rdChk(REG_TCODE_FMT, 32'h0, "fmt");
    rdChk(REG_TRIG_STAT, 32'h0, "stat");
    chk("fmtPort", 32'h0, {30'h0, timeCodeFormat});
    regWrite(REG_TCODE_FMT, 32'h2);
    waitCyc(1);
    chk("fmtPort", 32'h2, {30'h0, timeCodeFormat});
    rdChk(REG_TCODE_FMT, 32'h2, "fmt");
    regWrite(8'h20, 32'hff);
    rdChk(8'h20, 32'h0, "unmapped");
    regWrite(REG_PPO_MODE, 32'h1);
    regWrite(REG_PPO_MODE, 32'hc);
    rdChk(REG_PPO_MODE, 32'h1, "modeBad");
    for (int i = 0; i < 4; i++) begin
      regWrite(REG_PPS_WIDTH, 32'(i));
      marks(1);
      waitCyc(SEC - 20);
      chk("ppsWidth", 32'(wTab[i]), ppsWidth);
      chk("ppsRise", markAt + 2, ppsRise);
      chk("ppoWidth", 32'(wTab[i]), ppoWidth);
    end
    chk("ddsIdle", 32'h0, ddsRises);
    regWrite(REG_PPO_MODE, 32'h2);
    // a rate written mid-second can leave the output high across the next mark; count a full second later
    for (int m = 2; m <= 8; m++) begin
      marks(2);
      r0 = ppoRises;
      waitCyc(SEC - 8);
      chk("ppoRate", 32'(nPer(m)), ppoRises - r0);
      regWrite(REG_PPO_MODE, (m < 8) ? 32'(m + 1) : 32'hb);
    end
    marks(1);
    chk("invBefore", 32'h1, {31'h0, programmablePulseOutput});
    waitCyc(1);
    chk("invOnTime", 32'h0, {31'h0, programmablePulseOutput});
    regWrite(REG_PPS_WIDTH, 32'h2);
    sod = 13 * 3600 + 49 * 60 + 58;
    regWrite(REG_PPO_MODE, 32'h9);
    r0 = ppoRises;
    marks(3);
    waitCyc(3);
    chk("minuteCnt", 32'h1, ppoRises - r0);
    chk("minuteRise", markAt + 2, ppoRise);
    sod = 13 * 3600 + 50 * 60 + 13;
    regWrite(REG_PPO_MODE, 32'ha);
    waitCyc(300);
    r0 = ppoRises;
    marks(2);
    waitCyc(3);
    chk("evenCnt", 32'h1, ppoRises - r0);
    chk("evenRise", markAt + 2, ppoRise);
    regWrite(REG_PPO_MODE, 32'h0);
    sod = 14 * 3600 + 2;
    regWrite(REG_TRIG_ADD, trigWord(14, 0, 5));
    regWrite(REG_TRIG_ADD, trigWord(14, 0, 7));
    rdChk(REG_TRIG_STAT, 32'h3, "slots");
    marks(3);
    waitCyc(1100);
    rdChk(REG_TRIG_STAT, 32'h102, "armed");
    r0 = ppoRises;
    marks(1);
    waitCyc(3);
    chk("trigRise", markAt + 2, ppoRise);
    chk("trigCnt", 32'h1, ppoRises - r0);
    waitCyc(1100);
    rdChk(REG_TRIG_STAT, 32'h2, "disarmed");
    marks(2);
    waitCyc(300);
    chk("trigCnt2", 32'h2, ppoRises - r0);
    chk("trigWidth", 32'(wTab[2]), ppoWidth);
    marks(1);
    waitCyc(300);
    chk("trigAfter", 32'h2, ppoRises - r0);
    for (int i = 0; i < 5; i++) regWrite(REG_TRIG_ADD, trigWord(20, i, 0));
    rdChk(REG_TRIG_STAT, 32'h20f, "overflow");
    regWrite(REG_TRIG_STAT, 32'h200);
    rdChk(REG_TRIG_STAT, 32'h00f, "ovfClear");
    regWrite(REG_DDS_RATE, 32'h00ffffff);
    rdChk(REG_DDS_RATE, {8'h0, DDS_RATE_MAX}, "rateClamp");
    regWrite(REG_DDS_RATE, 32'd100);
    waitCyc(10);
    r0 = ddsRises;
    waitCyc(SEC);
    chkNear("dds100", 32'd100, ddsRises - r0);
    regWrite(REG_DDS_RATE, 32'd3);
    waitCyc(10);
    r0 = ddsRises;
    waitCyc(SEC);
    chkNear("dds3", 32'd3, ddsRises - r0);
    final_report();
  end
endmodule
